// file: src/esp_pkg.sv
/*
  Shared constants and types of the serial eeprom status, protect and read
  block. Assumes a 10 MHz system clock and an spi master working in mode 0.
*/
package esp_pkg;

  // ==========================================================================
  // timing
  localparam int unsigned CLK_PERIOD_NS  = 100;
  localparam int unsigned WRITE_TIME_MS  = 5;  // self-timed cycle tW
  localparam int unsigned NS_PER_MS      = 1000000;

  // ==========================================================================
  // array geometry
  localparam int ADDR_W    = 14;
  localparam int DATA_W    = 8;
  localparam int MEM_DEPTH = 16384;
  localparam int PIN_W     = 4;

  // ==========================================================================
  // instruction codes
  localparam logic [7:0] OP_LATCH_SET    = 8'h06;
  localparam logic [7:0] OP_LATCH_CLEAR  = 8'h04;
  localparam logic [7:0] OP_STATUS_READ  = 8'h05;
  localparam logic [7:0] OP_STATUS_WRITE = 8'h01;
  localparam logic [7:0] OP_ARRAY_READ   = 8'h03;

  // ==========================================================================
  // status byte layout
  localparam int ST_LOCK_BIT = 7;
  localparam int ST_BPH_BIT  = 3;
  localparam int ST_BPL_BIT  = 2;
  localparam int ST_WEL_BIT  = 1;
  localparam int ST_BUSY_BIT = 0;

  // ==========================================================================
  // block protect encodings and bounds
  localparam logic [1:0]        BP_NONE         = 2'h0;
  localparam logic [1:0]        BP_QUARTER      = 2'h1;
  localparam logic [1:0]        BP_HALF         = 2'h2;
  localparam logic [ADDR_W-1:0] PROT_QUART_BASE = 14'h3000;
  localparam logic [ADDR_W-1:0] PROT_HALF_BASE  = 14'h2000;

  // non-volatile bits after reset (delivery state)
  localparam logic LOCK_RESET = 1'b0;
  localparam logic [1:0] BP_RESET = 2'h0;

  // ==========================================================================
  // types
  typedef enum logic [2:0] {
    ESP_IDLE = 3'b000,
    ESP_CMD  = 3'b001,
    ESP_ADDR = 3'b010,
    ESP_RD   = 3'b011,
    ESP_STRD = 3'b100,
    ESP_STWR = 3'b101,
    ESP_WAIT = 3'b110
  } esp_state_t;

  typedef enum logic [1:0] {
    ESP_JOB_NONE   = 2'b00,
    ESP_JOB_STATUS = 2'b01,
    ESP_JOB_ARRAY  = 2'b10
  } esp_job_t;

  typedef struct packed {
    logic cs_n;
    logic sck;
    logic mosi;
    logic wp_n;
  } esp_pins_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } esp_wreq_t;

endpackage

// file: src/esp_sync.sv
/*
  Two-stage synchroniser for a group of pin inputs, one chain per bit.
  Assumes the inputs are asynchronous to clk and only the last stage is read.
*/
`timescale 1ns/10ps
`default_nettype none
module esp_sync #(
  parameter int W = 4
) (
  // clock, reset, enable
  input  wire logic         clk,
  input  wire logic         reset,
  input  wire logic         ce,
  // pins in, synchronised out
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  // ==========================================================================
  // one chain per bit
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      logic meta_reg;
      always_ff @(posedge clk) begin
        if (reset) begin
          meta_reg <= 1'b1;
          q[i]     <= 1'b1;
        end else if (ce) begin
          meta_reg <= d[i];
          q[i]     <= meta_reg;
        end
      end
    end
  endgenerate

endmodule
`default_nettype wire

// file: src/esp_array.sv
/*
  Eeprom array storage: one registered read port, one write port.
  Assumes writes are issued only at the end of a timed write cycle.
*/
`timescale 1ns/10ps
`default_nettype none
module esp_array (
  // clock and enable
  input  wire logic                      clk,
  input  wire logic                      ce,
  // read port
  input  wire logic [esp_pkg::ADDR_W-1:0] rd_addr,
  output logic      [esp_pkg::DATA_W-1:0] rd_data,
  // write port
  input  wire logic                      wr_en,
  input  wire esp_pkg::esp_wreq_t        wr_req
);
  import esp_pkg::*;

  logic [DATA_W-1:0] mem [0:MEM_DEPTH-1];

  // ==========================================================================
  // storage access
  always_ff @(posedge clk) begin
    if (ce) begin
      if (wr_en) begin
        mem[wr_req.addr] <= wr_req.data;
      end
      rd_data <= mem[rd_addr];
    end
  end

endmodule
`default_nettype wire

// file: src/esp_core.sv
/*
  Spi eeprom device side: latch commands, status read and write with the
  self-timed cycle, block and hardware protection, sequential array read.
  Assumes spi mode 0 (sample on sck rise, shift on fall), sck well below
  clk/4, and a local write engine that asks for array writes on wr_*.
*/
`timescale 1ns/10ps
`default_nettype none
module esp_core #(
  parameter int unsigned WRITE_TIME_NS = 5000000
) (
  // clock, reset, enable
  input  wire logic                clk,
  input  wire logic                reset,
  input  wire logic                ce,
  // spi pins
  input  wire esp_pkg::esp_pins_t  pins,
  output logic                     miso,
  output logic                     miso_oe_n,
  // local array write requests
  input  wire logic                wr_valid,
  input  wire esp_pkg::esp_wreq_t  wr_req,
  output logic                     wr_accept,
  output logic                     wr_refuse,
  // state view
  output logic                     hw_locked
);
  import esp_pkg::*;

  localparam int unsigned TW_RAW    = WRITE_TIME_NS / CLK_PERIOD_NS;
  localparam int unsigned TW_CYCLES = (TW_RAW > 0) ? TW_RAW : 1;
  localparam int          CNT_W     = $clog2(TW_CYCLES + 1);
  localparam logic [CNT_W-1:0] TW_LAST = CNT_W'(TW_CYCLES - 1);

  // ==========================================================================
  // declarations
  esp_pins_t         pins_s;
  logic              cs_d_reg;
  logic              sck_d_reg;
  logic              armed_reg;
  logic              sel;
  logic              cs_rise;
  logic              sck_rise;
  logic              sck_fall;
  logic [2:0]        bit_reg;
  logic [7:0]        shin_reg;
  logic [7:0]        in_byte;
  logic              byte_done;
  esp_state_t        state_reg;
  esp_state_t        state_next;
  logic              addr_cnt_reg;
  logic [7:0]        addr_hi_reg;
  logic              stwr_full_reg;
  logic [7:0]        stwr_data_reg;
  logic [ADDR_W-1:0] ptr_reg;
  logic [DATA_W-1:0] mem_q;
  logic [7:0]        dout_reg;
  logic              drive_reg;
  logic              wel_reg;
  logic              lock_reg;
  logic [1:0]        bp_reg;
  esp_job_t          job_reg;
  logic [CNT_W-1:0]  cnt_reg;
  esp_wreq_t         pend_reg;
  logic              busy;
  logic              hardware_locked_mode;
  logic [7:0]        status_byte;
  logic              stwr_go;
  logic              arr_go;
  logic              job_end;
  logic              arr_commit;
  logic              cmd_set;
  logic              cmd_clear;

  // ==========================================================================
  // pin synchronisers
  esp_sync #(
    .W (PIN_W)
  ) u_sync (
    .clk   (clk),
    .reset (reset),
    .ce    (ce),
    .d     (pins),
    .q     (pins_s)
  );

  // ==========================================================================
  // array storage
  esp_array u_array (
    .clk     (clk),
    .ce      (ce),
    .rd_addr (ptr_reg),
    .rd_data (mem_q),
    .wr_en   (arr_commit),
    .wr_req  (pend_reg)
  );

  // ==========================================================================
  // pin edges and power-up arming
  always_ff @(posedge clk) begin
    if (reset) begin
      cs_d_reg  <= 1'b1;
      sck_d_reg <= 1'b0;
      armed_reg <= 1'b0;
    end else if (ce) begin
      cs_d_reg  <= pins_s.cs_n;
      sck_d_reg <= pins_s.sck;
      if (pins_s.cs_n) begin
        armed_reg <= 1'b1;  // must see deselect before first select
      end
    end
  end

  // edge and level decode
  assign sel       = ~pins_s.cs_n & armed_reg;
  assign cs_rise   = pins_s.cs_n & ~cs_d_reg;
  assign sck_rise  = sel & pins_s.sck & ~sck_d_reg;
  assign sck_fall  = sel & ~pins_s.sck & sck_d_reg;
  assign in_byte   = {shin_reg[6:0], pins_s.mosi};
  assign byte_done = sck_rise & (bit_reg == 3'h7);

  // ==========================================================================
  // protection and status view
  assign busy = (job_reg != ESP_JOB_NONE);
  assign hardware_locked_mode  = lock_reg & ~pins_s.wp_n;

  // status byte, bits 6..4 fixed zero
  always_comb begin
    status_byte              = 8'h00;
    status_byte[ST_LOCK_BIT] = lock_reg;
    status_byte[ST_BPH_BIT]  = bp_reg[1];
    status_byte[ST_BPL_BIT]  = bp_reg[0];
    status_byte[ST_WEL_BIT]  = wel_reg;
    status_byte[ST_BUSY_BIT] = busy;
  end

  // area selected by the protect bits
  function automatic logic is_protected(input logic [1:0]        bp,
                                        input logic [ADDR_W-1:0] a);
    logic r;
    r = 1'b1;
    if (bp == BP_NONE) begin
      r = 1'b0;
    end else if (bp == BP_QUARTER) begin
      r = (a >= PROT_QUART_BASE);
    end else if (bp == BP_HALF) begin
      r = (a >= PROT_HALF_BASE);
    end
    return r;
  endfunction

  // ==========================================================================
  // bit counter and input shifter
  always_ff @(posedge clk) begin
    if (reset) begin
      bit_reg  <= 3'h0;
      shin_reg <= 8'h00;
    end else if (ce) begin
      if (!sel) begin
        bit_reg <= 3'h0;
      end else if (sck_rise) begin
        bit_reg  <= bit_reg + 3'h1;
        shin_reg <= in_byte;
      end
    end
  end

  // ==========================================================================
  // command state machine, next state
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ESP_IDLE: begin
        if (sel) begin
          state_next = ESP_CMD;
        end
      end
      ESP_CMD: begin
        if (byte_done) begin
          state_next = ESP_WAIT;
          if (in_byte == OP_STATUS_READ) begin
            state_next = ESP_STRD;
          end else if (in_byte == OP_STATUS_WRITE && wel_reg
                       && !hardware_locked_mode && !busy) begin
            state_next = ESP_STWR;
          end else if (in_byte == OP_ARRAY_READ && !busy) begin
            state_next = ESP_ADDR;
          end
        end
      end
      ESP_ADDR: begin
        if (byte_done && addr_cnt_reg) begin
          state_next = ESP_RD;
        end
      end
      ESP_STWR: begin
        if (sck_rise && stwr_full_reg) begin
          state_next = ESP_WAIT;
        end
      end
      ESP_RD, ESP_STRD, ESP_WAIT: begin
        state_next = state_reg;
      end
      default: begin
        state_next = ESP_IDLE;
      end
    endcase
    if (!sel) begin
      state_next = ESP_IDLE;
    end
  end

  // command state machine, state and byte bookkeeping
  always_ff @(posedge clk) begin
    if (reset) begin
      state_reg     <= ESP_IDLE;
      addr_cnt_reg  <= 1'b0;
      addr_hi_reg   <= 8'h00;
      stwr_full_reg <= 1'b0;
      stwr_data_reg <= 8'h00;
    end else if (ce) begin
      state_reg <= state_next;
      if (state_reg == ESP_IDLE) begin
        addr_cnt_reg  <= 1'b0;
        stwr_full_reg <= 1'b0;
      end
      if (state_reg == ESP_ADDR && byte_done) begin
        addr_cnt_reg <= 1'b1;
        addr_hi_reg  <= in_byte;
      end
      if (state_reg == ESP_STWR && byte_done) begin
        stwr_full_reg <= 1'b1;  // exactly one data byte
        stwr_data_reg <= in_byte;
      end
    end
  end

  // ==========================================================================
  // read address pointer
  always_ff @(posedge clk) begin
    if (reset) begin
      ptr_reg <= '0;
    end else if (ce) begin
      if (state_reg == ESP_ADDR && byte_done && addr_cnt_reg) begin
        ptr_reg <= {addr_hi_reg[ADDR_W-9:0], in_byte};
      end else if (state_reg == ESP_RD && byte_done) begin
        ptr_reg <= ptr_reg + 14'h0001;
      end
    end
  end

  // ==========================================================================
  // output shifter, loads a new byte on the fall after each boundary
  always_ff @(posedge clk) begin
    if (reset) begin
      dout_reg  <= 8'h00;
      drive_reg <= 1'b0;
    end else if (ce) begin
      if (!sel) begin
        drive_reg <= 1'b0;
      end else if (sck_fall && (state_reg == ESP_RD ||
                                state_reg == ESP_STRD)) begin
        drive_reg <= 1'b1;
        if (bit_reg != 3'h0) begin
          dout_reg <= {dout_reg[6:0], 1'b0};
        end else if (state_reg == ESP_STRD) begin
          dout_reg <= status_byte;
        end else begin
          dout_reg <= mem_q;
        end
      end
    end
  end

  // serial output pins
  assign miso      = dout_reg[7];
  assign miso_oe_n = ~(drive_reg & sel &
                       (state_reg == ESP_RD || state_reg == ESP_STRD));

  // ==========================================================================
  // write start conditions
  assign cmd_set   = (state_reg == ESP_CMD) & byte_done &
                     (in_byte == OP_LATCH_SET);
  assign cmd_clear = (state_reg == ESP_CMD) & byte_done &
                     (in_byte == OP_LATCH_CLEAR);
  assign stwr_go   = cs_rise & (state_reg == ESP_STWR) & stwr_full_reg &
                     wel_reg & ~hardware_locked_mode & ~busy;
  assign arr_go    = wr_valid & ~stwr_go & wel_reg & ~busy &
                     ~is_protected(bp_reg, wr_req.addr);
  assign job_end   = busy & (cnt_reg == TW_LAST);
  assign arr_commit = job_end & (job_reg == ESP_JOB_ARRAY);

  // ==========================================================================
  // timed write engine
  always_ff @(posedge clk) begin
    if (reset) begin
      job_reg  <= ESP_JOB_NONE;
      cnt_reg  <= '0;
      pend_reg <= '0;
    end else if (ce) begin
      if (job_end) begin
        job_reg <= ESP_JOB_NONE;
        cnt_reg <= '0;
      end else if (busy) begin
        cnt_reg <= cnt_reg + CNT_W'(1);
      end else if (stwr_go) begin
        job_reg       <= ESP_JOB_STATUS;
        pend_reg.data <= stwr_data_reg;
      end else if (arr_go) begin
        job_reg  <= ESP_JOB_ARRAY;
        pend_reg <= wr_req;
      end
    end
  end

  // write enable latch
  always_ff @(posedge clk) begin
    if (reset) begin
      wel_reg <= 1'b0;
    end else if (ce) begin
      if (cmd_set) begin
        wel_reg <= 1'b1;
      end else if (cmd_clear || job_end) begin
        wel_reg <= 1'b0;
      end
    end
  end

  // non-volatile lock and protect bits, applied only at cycle end
  always_ff @(posedge clk) begin
    if (reset) begin
      lock_reg <= LOCK_RESET;
      bp_reg   <= BP_RESET;
    end else if (ce) begin
      if (job_end && job_reg == ESP_JOB_STATUS) begin
        lock_reg <= pend_reg.data[ST_LOCK_BIT];
        bp_reg   <= {pend_reg.data[ST_BPH_BIT],
                     pend_reg.data[ST_BPL_BIT]};
      end
    end
  end

  // local write answers and lock view
  always_ff @(posedge clk) begin
    if (reset) begin
      wr_accept <= 1'b0;
      wr_refuse <= 1'b0;
      hw_locked <= 1'b0;
    end else if (ce) begin
      wr_accept <= arr_go;
      wr_refuse <= wr_valid & ~arr_go;
      hw_locked <= hardware_locked_mode;
    end
  end

endmodule
`default_nettype wire

// file: verification/esp_core_sva.sv
/*
  Port checks on the eeprom status, protect and read core.
  Assumes one clock domain; bound to every esp_core instance.
*/
`timescale 1ns/10ps
`default_nettype none
module esp_core_sva #(
  parameter int unsigned WRITE_TIME_NS = 5000000
) (
  // clock, reset, enable
  input wire logic               clk,
  input wire logic               reset,
  input wire logic               ce,
  // spi side
  input wire esp_pkg::esp_pins_t pins,
  input wire logic               miso,
  input wire logic               miso_oe_n,
  // local write port, state
  input wire logic               wr_valid,
  input wire esp_pkg::esp_wreq_t wr_req,
  input wire logic               wr_accept,
  input wire logic               wr_refuse,
  input wire logic               hw_locked
);
  import esp_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset || !ce);  // a frozen core answers nothing

  // ==========================================================================
  // sequences
  // a request that lands while the accepted write still runs
  sequence s_busy_req;
    wr_accept ##[1:3] wr_valid;
  endsequence
  // serial clock rise while selected
  sequence s_sel_rise;
    $rose(pins.sck) && !pins.cs_n;
  endsequence

  // ==========================================================================
  // assertions
  chk_reset_quiet: assert property (disable iff (1'b0)
    reset |=> miso_oe_n && !wr_accept && !wr_refuse && !hw_locked)
    else $error("outputs active after reset");
  chk_busy_refuse: assert property (
    s_busy_req |-> ##[1:2] wr_refuse)
    else $error("request during write cycle not refused");
  chk_answer_once: assert property (wr_accept |=> !wr_accept)
    else $error("accept pulse too long");
  chk_answer_cause: assert property (
    wr_accept || wr_refuse |-> $past(wr_valid) || $past(wr_valid, 2))
    else $error("answer without request");
  chk_answer_excl: assert property (wr_refuse |-> !wr_accept)
    else $error("accept and refuse together");
  chk_no_early: assert property ($fell(pins.cs_n) |-> miso_oe_n[*8])
    else $error("output driven during command byte");
  chk_release_idle: assert property (pins.cs_n[*5] |-> miso_oe_n)
    else $error("output driven while deselected");
  chk_unlock_pin: assert property (
    $rose(pins.wp_n) |-> ##[1:4] !hw_locked)
    else $error("locked mode kept with pin high");
  chk_bit_hold: assert property (s_sel_rise |=> $stable(miso)[*4])
    else $error("output bit changed after sampling rise");
endmodule

bind esp_core esp_core_sva #(.WRITE_TIME_NS(WRITE_TIME_NS)) u_sva (
  .clk(clk), .reset(reset), .ce(ce), .pins(pins), .miso(miso),
  .miso_oe_n(miso_oe_n), .wr_valid(wr_valid), .wr_req(wr_req),
  .wr_accept(wr_accept), .wr_refuse(wr_refuse), .hw_locked(hw_locked));
`default_nettype wire

// file: verification/esp_master.sv
/*
  Spi bus master model, mode 0, sck half period of four system clocks.
  Assumes a pull-up on the serial data output line.
*/
`timescale 1ns/10ps
`default_nettype none
module esp_master (
  // clock
  input  wire logic clk,
  // spi pins
  output logic      cs_n,
  output logic      sck,
  output logic      mosi,
  input  wire logic miso,
  input  wire logic miso_oe_n
);
  // ==========================================================================
  // idle levels: deselected, clock low
  initial begin
    cs_n = 1'b1;
    sck = 1'b0;
    mosi = 1'b0;
  end

  // half a serial clock period
  task automatic half;
    repeat (4) @(posedge clk);
    #5;
  endtask

  // one selected frame of n bits, msb first; cs rises after the last fall
  task automatic frame(input logic [47:0] tx, input int n,
                       output logic [47:0] rx);
    rx = '0;
    half();
    cs_n = 1'b0;
    for (int i = n - 1; i >= 0; i--) begin
      mosi = tx[i];
      half();
      sck = 1'b1;
      rx[i] = miso_oe_n ? 1'b1 : miso;  // pull-up when released
      half();
      sck = 1'b0;
    end
    half();
    cs_n = 1'b1;
    mosi = ~mosi;  // released line does not hold its value
    half();
    half();
  endtask
endmodule
`default_nettype wire

// file: verification/esp_core_bench.sv
/*
  Self-checking bench of the eeprom status, protect and read core.
  Assumes the master model drives the spi pins; clock enable is dropped
  once, while the link is idle, to see that the core holds its state.
*/
`timescale 1ns/10ps
`default_nettype none
module esp_core_bench;
  import esp_pkg::*;
  // ==========================================================================
  // signals
  localparam int unsigned TW_NS = 40000;  // 400 clk write cycle
  logic        clk = 1'b0;
  logic        reset = 1'b1;
  logic        ce = 1'b1;
  logic        wp_n = 1'b1;
  logic        wr_valid = 1'b0;
  esp_wreq_t   wr_req = '0;
  logic        m_cs_n, m_sck, m_mosi, miso, miso_oe_n;
  logic        wr_accept, wr_refuse, hw_locked, acc;
  logic [7:0]  s;
  logic [47:0] rx;
  esp_pins_t   pins;
  int          mismatches = 0;
  int          n_tests = 0;

  // clock and pin bundle
  always #50 clk = ~clk;
  assign pins = {m_cs_n, m_sck, m_mosi, wp_n};

  esp_master m (.clk(clk), .cs_n(m_cs_n), .sck(m_sck), .mosi(m_mosi),
    .miso(miso), .miso_oe_n(miso_oe_n));
  esp_core #(.WRITE_TIME_NS(TW_NS)) dut (.clk(clk), .reset(reset),
    .ce(ce), .pins(pins), .miso(miso), .miso_oe_n(miso_oe_n),
    .wr_valid(wr_valid), .wr_req(wr_req), .wr_accept(wr_accept),
    .wr_refuse(wr_refuse), .hw_locked(hw_locked));

  // ==========================================================================
  // helpers
  task automatic check(input string what, input logic [7:0] exp, got);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic op(input logic [7:0] code);
    m.frame({40'h0, code}, 8, rx);
  endtask
  task automatic status_read_cmd(output logic [7:0] st);
    m.frame({32'h0, OP_STATUS_READ, 8'h00}, 16, rx);
    st = rx[7:0];
  endtask
  task automatic status_write_cmd(input logic [7:0] d);
    op(OP_LATCH_SET);
    m.frame({32'h0, OP_STATUS_WRITE, d}, 16, rx);
  endtask
  task automatic pin_wp(input logic v);
    @(posedge clk);
    #5 wp_n = v;
    repeat (6) @(posedge clk);
    #5;
  endtask
  // poll the busy bit, bounded
  task automatic wait_idle;
    logic [7:0] st;
    for (int i = 0; i < 40; i++) begin
      status_read_cmd(st);
      if (st[ST_BUSY_BIT] === 1'b0) return;
    end
    mismatches++;
    end_of_test();
  endtask
  // one local write request; acc tells whether it was taken
  task automatic lwrite(input logic [13:0] a, input logic [7:0] d,
                        output logic ok);
    logic a1, r1;
    @(posedge clk);
    #5 wr_valid = 1'b1;
    wr_req = {a, d};
    @(posedge clk);
    #5 wr_valid = 1'b0;
    a1 = wr_accept;
    r1 = wr_refuse;
    @(posedge clk);
    #5 ok = a1 | wr_accept;
    check("single answer", {7'h0, ~ok}, {7'h0, r1 | wr_refuse});
  endtask

  // ==========================================================================
  // scenarios
  task automatic t_reset_view;
    status_read_cmd(s);
    check("status after reset", 8'h00, s);
    op(OP_LATCH_SET);
    m.frame({24'h0, OP_STATUS_READ, 16'h0}, 24, rx);
    check("status first", 8'h02, rx[15:8]);
    check("status repeat", 8'h02, rx[7:0]);
  endtask
  task automatic t_latch;
    m.frame({32'h0, OP_LATCH_CLEAR, 8'hFF}, 16, rx);
    status_read_cmd(s);
    check("latch cleared", 8'h00, s);
    lwrite(14'h0100, 8'h33, acc);
    check("write without latch", 8'h00, {7'h0, acc});
    m.frame({32'h0, OP_STATUS_WRITE, 8'h8C}, 16, rx);
    status_read_cmd(s);
    check("status write without latch", 8'h00, s);
  endtask
  task automatic t_status_lock;
    pin_wp(1'b0);
    status_write_cmd(8'hFF);
    status_read_cmd(s);
    check("status during cycle", 8'h03, s);
    wait_idle();
    status_read_cmd(s);
    check("status after cycle", 8'h8C, s);
    check("locked, lock last", 8'h01, {7'h0, hw_locked});
    status_write_cmd(8'h00);
    status_read_cmd(s);
    check("locked status write", 8'h8E, s);
    ce = 1'b0;
    pin_wp(1'b1);
    check("frozen lock view", 8'h01, {7'h0, hw_locked});
    ce = 1'b1;
    pin_wp(1'b1);
    check("pin high unlocks", 8'h00, {7'h0, hw_locked});
    pin_wp(1'b0);
    check("locked, pin last", 8'h01, {7'h0, hw_locked});
    pin_wp(1'b1);
    status_write_cmd(8'h00);
    wait_idle();
    status_read_cmd(s);
    check("lock set, pin high", 8'h00, s);
  endtask
  task automatic t_bit_count;
    op(OP_LATCH_SET);
    m.frame({31'h0, OP_STATUS_WRITE, 8'h84, 1'b0}, 17, rx);
    status_read_cmd(s);
    check("ninth data bit", 8'h02, s);
  endtask
  task automatic t_protect;
    logic [13:0] a;
    logic exp;
    for (int b = 3; b >= 0; b--) begin
      status_write_cmd({4'h0, b[1:0], 2'h0});
      wait_idle();
      for (int k = 0; k < 4; k++) begin
        a = k[1] ? (k[0] ? 14'h3000 : 14'h2FFF) : (k[0] ? 14'h2000 : 14'h1FFF);
        exp = (b == 0) || (b == 1 && a < 14'h3000) || (b == 2 && a < 14'h2000);
        op(OP_LATCH_SET);
        lwrite(a, a[7:0], acc);
        check("protect area", {7'h0, exp}, {7'h0, acc});
        if (acc) wait_idle();
      end
    end
  endtask
  task automatic t_read;
    op(OP_LATCH_SET);
    lwrite(14'h3FFF, 8'h5A, acc);
    wait_idle();
    op(OP_LATCH_SET);
    lwrite(14'h0000, 8'hC3, acc);
    wait_idle();
    m.frame({8'h0, OP_ARRAY_READ, 16'hFFFF, 16'h0}, 40, rx);
    check("read first", 8'h5A, rx[15:8]);
    check("read wrapped", 8'hC3, rx[7:0]);
    m.frame({20'h0, OP_ARRAY_READ, 16'h3FFF, 4'h0}, 28, rx);
    check("released mid byte", 8'h01, {7'h0, miso_oe_n});
    check("read mid byte", 8'h05, {4'h0, rx[3:0]});
    op(OP_LATCH_SET);
    lwrite(14'h1234, 8'h11, acc);
    lwrite(14'h1235, 8'h22, acc);
    check("write while busy", 8'h00, {7'h0, acc});
    m.frame({16'h0, OP_ARRAY_READ, 16'h3FFF, 8'h0}, 32, rx);
    check("read while busy", 8'hFF, rx[7:0]);
    wait_idle();
    status_read_cmd(s);
    check("latch after array write", 8'h00, s);
    m.frame({16'h0, OP_ARRAY_READ, 16'h1234, 8'h0}, 32, rx);
    check("written byte", 8'h11, rx[7:0]);
  endtask

  // ==========================================================================
  // closing report
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // main sequence
  initial begin
    repeat (6) @(posedge clk);
    #5 reset = 1'b0;
    repeat (4) @(posedge clk);
    t_reset_view();
    t_latch();
    t_status_lock();
    t_bit_count();
    t_protect();
    t_read();
    end_of_test();
  end
endmodule
`default_nettype wire
